// ### coproc_branch_subtract_low_immediate_exec.sv
// Execute unit for the signed greater-than branch and immediate-byte subtract
`include "coproc_branch_subtract_low_immediate_regs.svh"
//
// Contract
// - Branch taken when Z clear, N equals V
// - Taken target is PC plus 2 plus offset*2
// - Subtract zero-extended byte from destination, write back
// - N follows result bit 15
// - Z set when result is zero
// - V set when old sign 1, new 0
// - C set when old sign 0, new 1
// - Subtract opcode 11000, one fetch cycle
module coproc_branch_subtract_low_immediate_exec #(
  parameter logic [15:0] RESET_PC = `PC_RESET
) (
  input  wire logic                                     i_clk_sys,
  input  wire logic                                     i_rst,
  input  wire coproc_branch_subtract_low_immediate_pkg::instr_t           i_instr,
  input  wire coproc_branch_subtract_low_immediate_pkg::reg_write_t       i_reg_load,
  input  wire coproc_branch_subtract_low_immediate_pkg::flag_load_t       i_flag_load,
  input  wire coproc_branch_subtract_low_immediate_pkg::pc_load_t         i_pc_load,
  input  wire logic [2:0]                               i_view_sel,
  output coproc_branch_subtract_low_immediate_pkg::condition_flags_t      o_flags,
  output coproc_branch_subtract_low_immediate_pkg::reg_write_t            o_writeback,
  output logic      [15:0]                              o_pc,
  output logic                                          o_ready,
  output logic                                          o_branch_taken,
  output logic                                          o_unknown_op,
  output logic      [15:0]                              o_view
);
  import coproc_branch_subtract_low_immediate_pkg::*;

  core_state_t       cur;
  core_state_t       next_cur;
  condition_flags_t  alu_flags;
  logic [15:0]       alu_result;
  logic [2:0]        dest_idx;
  logic              accept;

  // Upper seven bits only, bit 8 is already the offset sign
  function automatic logic is_branch_signed_greater(input logic [15:0] w);
    is_branch_signed_greater =
      (w[`OPC_BRANCH_MSB:`OPC_BRANCH_LSB] == `OPC_BRANCH_SG);
  endfunction : is_branch_signed_greater

  function automatic logic [15:0] seq_pc(input logic [15:0] pc);
    seq_pc = pc + `PC_STEP;
  endfunction : seq_pc

  function automatic logic is_subtract_low_immediate(input logic [15:0] w);
    is_subtract_low_immediate = (w[`OPC_SUBTRACT_LOW_IMMEDIATE_MSB:`OPC_SUBTRACT_LOW_IMMEDIATE_LSB] == `OPC_SUBTRACT_LOW_IMMEDIATE);
  endfunction : is_subtract_low_immediate

  function automatic logic greater_holds(input condition_flags_t f);
    greater_holds = ~(f.z | (f.n ^ f.v));
  endfunction : greater_holds

  function automatic logic [15:0] branch_target(input logic [15:0] pc,
                                                input logic [15:0] w);
    logic [8:0]  branch_offset_field;
    logic [15:0] byte_offset;
    branch_offset_field = w[`BR_OFS_MSB:`BR_OFS_LSB];
    byte_offset   = {{6{branch_offset_field[8]}}, branch_offset_field, 1'b0};
    branch_target = seq_pc(pc) + byte_offset;
  endfunction : branch_target

  function automatic core_state_t reset_state();
    core_state_t s;
    s         = '0;
    s.st      = ST_EXEC;
    s.pc      = RESET_PC;
    s.flags   = `FLAGS_RESET;
    s.ready   = 1'b1;
    for (int i = 0; i < `REG_COUNT; i++) begin
      s.regs[i] = `REG_RESET;
    end
    reset_state = s;
  endfunction : reset_state

  assign dest_idx = i_instr.word[`RD_MSB:`RD_LSB];
  assign accept   = cur.ready & i_instr.valid;

  subtract_low_immediate_alu i_subtract_low_immediate_alu (
    .i_rd_old         (cur.regs[dest_idx]),
    .i_immediate_byte (i_instr.word[`IMM_MSB:`IMM_LSB]),
    .o_flags          (alu_flags),
    .o_result         (alu_result)
  );

  always_comb begin
    next_cur          = cur;
    next_cur.wb.valid = 1'b0;
    next_cur.taken    = 1'b0;
    next_cur.unknown  = 1'b0;
    next_cur.view     = cur.regs[i_view_sel];
    case (cur.st)
      ST_EXEC: begin
        if (accept) begin
          if (is_branch_signed_greater(i_instr.word)) begin
            // Flags stay untouched on either outcome
            if (greater_holds(cur.flags)) begin
              next_cur.pc    = branch_target(cur.pc, i_instr.word);
              next_cur.st    = ST_REFILL;
              next_cur.ready = 1'b0;
              next_cur.taken = 1'b1;
            end else begin
              next_cur.pc = seq_pc(cur.pc);
            end
          end else if (is_subtract_low_immediate(i_instr.word)) begin
            next_cur.regs[dest_idx] = alu_result;
            next_cur.flags          = alu_flags;
            next_cur.wb.valid       = 1'b1;
            next_cur.wb.idx         = dest_idx;
            next_cur.wb.data        = alu_result;
            next_cur.pc             = seq_pc(cur.pc);
          end else begin
            next_cur.unknown = 1'b1;
            next_cur.pc      = seq_pc(cur.pc);
          end
        end else begin
          // Side loads only in idle cycles, so execution never races them
          if (i_reg_load.valid) begin
            next_cur.regs[i_reg_load.idx] = i_reg_load.data;
          end
          if (i_flag_load.valid) begin
            next_cur.flags = i_flag_load.flags;
          end
          if (i_pc_load.valid) begin
            next_cur.pc = i_pc_load.pc;
          end
        end
      end
      ST_REFILL: begin
        // Second program-fetch cycle of a taken branch
        next_cur.st    = ST_EXEC;
        next_cur.ready = 1'b1;
      end
      default: begin
        next_cur = reset_state();
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cur <= reset_state();
    end else begin
      cur <= next_cur;
    end
  end

  assign o_flags        = cur.flags;
  assign o_writeback    = cur.wb;
  assign o_pc           = cur.pc;
  assign o_ready        = cur.ready;
  assign o_branch_taken = cur.taken;
  assign o_unknown_op   = cur.unknown;
  assign o_view         = cur.view;

endmodule : coproc_branch_subtract_low_immediate_exec

// ### coproc_branch_subtract_low_immediate_exec_sva.sv
// Port assertions of the branch and immediate-subtract execute unit
module coproc_branch_subtract_low_immediate_exec_sva (
  input wire logic                                     i_clk_sys,
  input wire logic                                     i_rst,
  input wire coproc_branch_subtract_low_immediate_pkg::instr_t           i_instr,
  input wire coproc_branch_subtract_low_immediate_pkg::reg_write_t       i_reg_load,
  input wire coproc_branch_subtract_low_immediate_pkg::flag_load_t       i_flag_load,
  input wire coproc_branch_subtract_low_immediate_pkg::pc_load_t         i_pc_load,
  input wire logic [2:0]                               i_view_sel,
  input wire coproc_branch_subtract_low_immediate_pkg::condition_flags_t o_flags,
  input wire coproc_branch_subtract_low_immediate_pkg::reg_write_t       o_writeback,
  input wire logic [15:0]                              o_pc,
  input wire logic                                     o_ready,
  input wire logic                                     o_branch_taken,
  input wire logic                                     o_unknown_op,
  input wire logic [15:0]                              o_view
);
  import coproc_branch_subtract_low_immediate_pkg::*;
  logic        acc, br, sub, go, unk;
  logic [15:0] tgt, old;
  logic [7:0]  imm_q;
  assign acc = i_instr.valid && o_ready;
  assign br  = acc && (i_instr.word[15:9] == 7'h1C);
  assign sub = acc && (i_instr.word[15:11] == 5'h18);
  assign unk = acc && !br && !sub;
  assign go  = !o_flags.z && (o_flags.n == o_flags.v);
  assign tgt = o_pc + 16'h0002 + {{6{i_instr.word[8]}}, i_instr.word[8:0], 1'b0};
  // Old destination rebuilt from difference plus immediate
  assign old = o_writeback.data + {8'h00, imm_q};
  always_ff @(posedge i_clk_sys) begin
    imm_q <= i_instr.word[7:0];
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  br_flags_keep_a: assert property (br |=> o_flags == $past(o_flags))
    else $error("branch changed flags");
  br_target_a: assert property (
    br && go |=> o_branch_taken && o_pc == $past(tgt))
    else $error("taken branch target wrong");
  br_refill_a: assert property (br && go |=> !o_ready ##1 o_ready)
    else $error("taken branch timing wrong");
  br_skip_a: assert property (
    br && !go |=> !o_branch_taken && o_ready && o_pc == $past(o_pc) + 16'h0002)
    else $error("branch taken wrongly");
  taken_cause_a: assert property (o_branch_taken |-> $past(br && go))
    else $error("taken pulse without cause");
  sub_wb_a: assert property (
    sub |=> o_writeback.valid && o_writeback.idx == $past(i_instr.word[10:8]) && o_ready)
    else $error("subtract writeback wrong");
  sub_nz_a: assert property (
    sub |=> o_flags.n == o_writeback.data[15] &&
            o_flags.z == (o_writeback.data == 16'h0000))
    else $error("subtract n or z wrong");
  sub_vc_a: assert property (
    sub |=> o_flags.v == (old[15] && !o_writeback.data[15]) &&
            o_flags.c == (!old[15] && o_writeback.data[15]))
    else $error("subtract v or c wrong");
  unk_step_a: assert property (
    unk |=> o_unknown_op && !o_writeback.valid && !o_branch_taken &&
            o_flags == $past(o_flags) && o_pc == $past(o_pc) + 16'h0002)
    else $error("unknown word handled wrongly");
  cover property (br && go);
  cover property (br && !go);
  cover property (sub);
  cover property (unk);
endmodule : coproc_branch_subtract_low_immediate_exec_sva

bind coproc_branch_subtract_low_immediate_exec coproc_branch_subtract_low_immediate_exec_sva i_coproc_branch_subtract_low_immediate_exec_sva (
  .i_clk_sys      (i_clk_sys),
  .i_rst          (i_rst),
  .i_instr        (i_instr),
  .i_reg_load     (i_reg_load),
  .i_flag_load    (i_flag_load),
  .i_pc_load      (i_pc_load),
  .i_view_sel     (i_view_sel),
  .o_flags        (o_flags),
  .o_writeback    (o_writeback),
  .o_pc           (o_pc),
  .o_ready        (o_ready),
  .o_branch_taken (o_branch_taken),
  .o_unknown_op   (o_unknown_op),
  .o_view         (o_view)
);

// ### coproc_branch_subtract_low_immediate_pkg.sv
// Types shared by the coprocessor branch and immediate-subtract execute unit
package coproc_branch_subtract_low_immediate_pkg;
`include "coproc_branch_subtract_low_immediate_regs.svh"

  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } condition_flags_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } instr_t;

  typedef struct packed {
    logic                  valid;
    logic [`REG_IDX_W-1:0] idx;
    logic [`DATA_W-1:0]    data;
  } reg_write_t;

  typedef struct packed {
    logic             valid;
    condition_flags_t flags;
  } flag_load_t;

  typedef struct packed {
    logic               valid;
    logic [`DATA_W-1:0] pc;
  } pc_load_t;

  typedef enum logic {
    ST_EXEC,
    ST_REFILL
  } exec_state_t;

  typedef struct packed {
    exec_state_t                          st;
    logic [`DATA_W-1:0]                   pc;
    condition_flags_t                     flags;
    logic [`REG_COUNT-1:0][`DATA_W-1:0]   regs;
    reg_write_t                           wb;
    logic                                 ready;
    logic                                 taken;
    logic                                 unknown;
    logic [`DATA_W-1:0]                   view;
  } core_state_t;

endpackage : coproc_branch_subtract_low_immediate_pkg

// ### coproc_branch_subtract_low_immediate_regs.svh
// Constants of the coprocessor branch and immediate-subtract execute unit
`ifndef COPROC_BRANCH_SUBTRACT_LOW_IMMEDIATE_REGS_SVH
`define COPROC_BRANCH_SUBTRACT_LOW_IMMEDIATE_REGS_SVH

`define REG_COUNT         8
`define REG_IDX_W         3
`define DATA_W            16

`define OPC_BRANCH_SG     7'h1C
`define OPC_BRANCH_MSB    15
`define OPC_BRANCH_LSB    9
`define OPC_SUBTRACT_LOW_IMMEDIATE          5'h18
`define OPC_SUBTRACT_LOW_IMMEDIATE_MSB      15
`define OPC_SUBTRACT_LOW_IMMEDIATE_LSB      11

`define BR_OFS_MSB        8
`define BR_OFS_LSB        0
`define RD_MSB            10
`define RD_LSB            8
`define IMM_MSB           7
`define IMM_LSB           0
`define SIGN_BIT          15

`define PC_STEP           16'h0002
`define PC_RESET          16'h0000
`define FLAGS_RESET       4'h0
`define REG_RESET         16'h0000
`define ZERO_WORD         16'h0000
`define IMM_HI_FILL       8'h00

`endif

// ### subtract_low_immediate_alu.sv
// Difference and flags of the immediate-byte subtraction
`include "coproc_branch_subtract_low_immediate_regs.svh"
module subtract_low_immediate_alu (
  input  wire logic [15:0]                             i_rd_old,
  input  wire logic [7:0]                              i_immediate_byte,
  output coproc_branch_subtract_low_immediate_pkg::condition_flags_t     o_flags,
  output logic      [15:0]                             o_result
);
  import coproc_branch_subtract_low_immediate_pkg::*;

  logic [15:0] diff;

  always_comb begin
    diff           = i_rd_old - {`IMM_HI_FILL, i_immediate_byte};
    o_result       = diff;
    o_flags.n      = diff[`SIGN_BIT];
    o_flags.z      = (diff == `ZERO_WORD);
    o_flags.v      = i_rd_old[`SIGN_BIT] & ~diff[`SIGN_BIT];
    o_flags.c      = ~i_rd_old[`SIGN_BIT] & diff[`SIGN_BIT];
  end

endmodule : subtract_low_immediate_alu

// ### test_coproc_branch_subtract_low_immediate_exec.sv
// Self-checking bench of the branch and immediate-subtract execute unit
module test_coproc_branch_subtract_low_immediate_exec;
  timeunit 1ns;
  timeprecision 1ps;
  import coproc_branch_subtract_low_immediate_pkg::*;
  typedef struct packed {
    logic [3:0]  fl;
    logic [15:0] rv, wd, pc, dat;
    logic [3:0]  efl;
    logic        tk;
  } row_t;
  row_t rows [9] = '{
    '{4'h0, 16'h0000, 16'h3805, 16'h010C, 16'h0000, 4'h0, 1'b1},
    '{4'hA, 16'h0000, 16'h39FF, 16'h0100, 16'h0000, 4'hA, 1'b1},
    '{4'h1, 16'h0000, 16'h3900, 16'hFF02, 16'h0000, 4'h1, 1'b1},
    '{4'h4, 16'h0000, 16'h3805, 16'h0102, 16'h0000, 4'h4, 1'b0},
    '{4'h8, 16'h0000, 16'h3805, 16'h0102, 16'h0000, 4'h8, 1'b0},
    '{4'hF, 16'h0005, 16'hC305, 16'h0102, 16'h0000, 4'h4, 1'b0},
    '{4'h0, 16'h0000, 16'hC001, 16'h0102, 16'hFFFF, 4'h9, 1'b0},
    '{4'hF, 16'h8000, 16'hC701, 16'h0102, 16'h7FFF, 4'h2, 1'b0},
    '{4'hF, 16'h1234, 16'hC5FF, 16'h0102, 16'h1135, 4'h0, 1'b0}};
  logic             clk_sys = 1'b0;
  logic             rst = 1'b1;
  instr_t           instr = '0;
  reg_write_t       reg_load = '0;
  flag_load_t       flag_load = '0;
  pc_load_t         pc_load = '0;
  logic [2:0]       view_sel = 3'h1;
  condition_flags_t flags;
  reg_write_t       wb;
  logic [15:0]      pc, view;
  logic             ready, taken, unknown;
  int               num_errors = 0;
  int               checked = 0;
  int               cycles = 0;
  always #12.5 clk_sys = ~clk_sys;
  coproc_branch_subtract_low_immediate_exec i_coproc_branch_subtract_low_immediate_exec (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_instr(instr), .i_reg_load(reg_load),
    .i_flag_load(flag_load), .i_pc_load(pc_load), .i_view_sel(view_sel), .o_flags(flags),
    .o_writeback(wb), .o_pc(pc), .o_ready(ready), .o_branch_taken(taken),
    .o_unknown_op(unknown), .o_view(view));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic preload(input logic [15:0] p, input logic [3:0] f, input logic [2:0] ix,
                         input logic [15:0] v);
    @(posedge clk_sys);
    pc_load   <= '{1'b1, p};
    flag_load <= '{1'b1, f};
    reg_load  <= '{1'b1, ix, v};
    @(posedge clk_sys);
    pc_load.valid   <= 1'b0;
    flag_load.valid <= 1'b0;
    reg_load.valid  <= 1'b0;
  endtask : preload
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    check(pc, 16'h0000);
    check({12'h000, flags, 15'h0000, ready}, {16'h0000, 16'h0001});
    foreach (rows[k]) begin
      preload(16'h0100, rows[k].fl, rows[k].wd[10:8], rows[k].rv);
      instr <= '{1'b1, rows[k].wd};
      @(posedge clk_sys);
      instr.valid <= 1'b0;
      #1;
      check(pc, rows[k].pc);
      check({12'h000, flags}, {12'h000, rows[k].efl});
      check({15'h0000, taken}, {15'h0000, rows[k].tk});
      if (rows[k].wd[15]) begin
        check({wb.valid, wb.idx, wb.data}, {1'b1, rows[k].wd[10:8], rows[k].dat});
      end
    end
    // Back-to-back subtracts on one register
    preload(16'h0100, 4'h0, 3'h1, 16'h0003);
    instr <= '{1'b1, 16'hC102};
    @(posedge clk_sys);
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    @(posedge clk_sys);
    #1;
    check(view, 16'hFFFF);
    check({pc, 12'h000, flags}, {16'h0104, 16'h0009});
    // Offer held through the refill cycle is ignored
    preload(16'h0200, 4'h0, 3'h0, 16'h0000);
    instr <= '{1'b1, 16'h3801};
    @(posedge clk_sys);
    #1;
    check({pc, 15'h0000, ready}, {16'h0204, 16'h0000});
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    #1;
    check({pc, 15'h0000, ready}, {16'h0204, 16'h0001});
    // Unrecognised word steps the program counter and pulses the unknown-op flag, nothing else
    @(posedge clk_sys);
    instr <= '{1'b1, 16'h0000};
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    #1;
    check({pc, 10'h000, flags, taken, unknown}, {16'h0206, 16'h0001});
    // Reset in mid-run, then a subtract on the first edge after release
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    #1;
    check({pc, view}, 32'h0000_0000);
    check({12'h000, flags, 12'h000, wb.valid, taken, unknown, ready}, 32'h0000_0001);
    @(posedge clk_sys);
    rst   <= 1'b0;
    instr <= '{1'b1, 16'hC001};
    @(posedge clk_sys);
    instr.valid <= 1'b0;
    #1;
    check({pc, 12'h000, flags}, {16'h0002, 16'h0009});
    check({wb.valid, wb.idx, wb.data}, {1'b1, 3'h0, 16'hFFFF});
    final_report();
  end
endmodule : test_coproc_branch_subtract_low_immediate_exec
